/* File: include/tlfr_regs.vh */
// command codes, field positions and reset values of the temperature limits
// Summary of operation
// - Delay field n selects 2 to the n delay units, 1 to 128.
// - Length of one delay unit comes from the delay_unit_cycles input.
// - One delay count serves as run-on time or restart spacing.
// - Over-temperature warning limit, 16-bit linear, word access at 0x51.
// - Under-temperature warning limit, 16-bit linear, word access at 0x52.
// - Under-temperature fault limit, 16-bit linear, word access at 0x53.
// - Fault action byte at 0x54: response 7:6, retries 5:3, delay 2:0.
// - Response 00 keeps the output running through a fault.
// - Response 01 runs for the delay, then retries if fault remains.
// - Response 10 disables the output at once, then retries.
// - Response 11 latches off until status clear, clear-faults or reset.
// - Commanding the output off then on also clears a latched fault.
// - Retry setting 000 makes no restart; output stays off until cleared.
// - Settings 001 to 110 give 1 to 6 attempts spaced by the delay.
// - Setting 111 retries forever until commanded off.
`ifndef TLFR_REGS_VH
`define TLFR_REGS_VH

`define TLFR_CMD_CLEAR_FAULTS 8'h03
`define TLFR_CMD_STATUS 8'h7D
`define TLFR_CMD_OT_WARN 8'h51
`define TLFR_CMD_UT_WARN 8'h52
`define TLFR_CMD_UT_FAULT 8'h53
`define TLFR_CMD_UT_ACTION 8'h54

`define TLFR_RESP_HI 7
`define TLFR_RESP_LO 6
`define TLFR_RETRY_HI 5
`define TLFR_RETRY_LO 3
`define TLFR_DELAY_HI 2
`define TLFR_DELAY_LO 0

`define TLFR_STAT_OT_WARN 6
`define TLFR_STAT_UT_WARN 5
`define TLFR_STAT_UT_FAULT 4

`define TLFR_RST_OT_WARN 16'h0000
`define TLFR_RST_UT_WARN 16'h0000
`define TLFR_RST_UT_FAULT 16'h0000
`define TLFR_RST_UT_ACTION 8'hC0

`define TLFR_LIN_EXP_OFS 5'h10

`endif

/* File: rtl/tlfr_delay_timer.v */
// delay timer: 2 to the n units, each unit a programmable cycle count
`timescale 1ns/1ps
module tlfr_delay_timer #(
  parameter UNIT_W = 16
) (
  input wire clk_sys,
  input wire reset,
  input wire start,
  input wire [2:0] exp_sel,
  input wire [UNIT_W-1:0] unit_cycles,
  output wire busy,
  output reg done
);

  reg run_reg;
  reg [UNIT_W-1:0] cyc_reg;
  reg [7:0] units_reg;
  reg [7:0] target_reg;
  wire [UNIT_W-1:0] unit_last;

  // a zero unit length would wrap to the longest unit, so it counts as one cycle
  assign unit_last = (unit_cycles == {UNIT_W{1'b0}}) ? {UNIT_W{1'b0}} :
    unit_cycles - {{(UNIT_W-1){1'b0}}, 1'b1};
  assign busy = run_reg;

  always @(posedge clk_sys) begin
    if (reset) begin
      run_reg <= 1'b0;
      cyc_reg <= {UNIT_W{1'b0}};
      units_reg <= 8'h00;
      target_reg <= 8'h01;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        run_reg <= 1'b1;
        cyc_reg <= {UNIT_W{1'b0}};
        units_reg <= 8'h00;
        target_reg <= 8'h01 << exp_sel;
      end else if (run_reg) begin
        if (cyc_reg >= unit_last) begin
          cyc_reg <= {UNIT_W{1'b0}};
          if (units_reg + 8'h01 == target_reg) begin
            run_reg <= 1'b0;
            done <= 1'b1;
          end else begin
            units_reg <= units_reg + 8'h01;
          end
        end else begin
          cyc_reg <= cyc_reg + {{(UNIT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // tlfr_delay_timer

/* File: rtl/tlfr_top.v */
// temperature limits, management link slave and under-temp fault action
`timescale 1ns/1ps
`include "tlfr_regs.vh"
module tlfr_top #(
  parameter DEV_ADDR = 7'h40,
  parameter UNIT_W = 16
) (
  input wire clk_sys,
  input wire reset,
  input wire pmb_scl_in,
  input wire pmb_sda_in,
  output wire pmb_sda_out,
  output wire pmb_sda_oe_n,
  input wire ctrl_on_in,
  input wire operation_on,
  input wire [UNIT_W-1:0] delay_unit_cycles,
  input wire [15:0] temp_meas,
  output reg power_enable,
  output reg ot_warning,
  output reg ut_warning,
  output reg ut_fault,
  output reg fault_latched
);

  //////////////////////////////////////////////////////////////////////////
  localparam PS_IDLE = 3'd0;
  localparam PS_ADDR = 3'd1;
  localparam PS_CMD = 3'd2;
  localparam PS_WDATA = 3'd3;
  localparam PS_RDATA = 3'd4;

  localparam ST_OFF = 3'd0;
  localparam ST_RUN = 3'd1;
  localparam ST_HOLD = 3'd2;
  localparam ST_WAIT = 3'd3;
  localparam ST_TRY = 3'd4;
  localparam ST_LATCH = 3'd5;

  // linear format: 5-bit signed exponent over 11-bit signed mantissa
  function signed [42:0] lin_fix;
    input [15:0] v;
    reg [4:0] sh;
    reg signed [42:0] m;
    begin
      sh = v[15:11] + `TLFR_LIN_EXP_OFS;
      m = {{32{v[10]}}, v[10:0]};
      lin_fix = m <<< sh;
    end
  endfunction

  function cmd_known;
    input [7:0] c;
    begin
      case (c)
        `TLFR_CMD_CLEAR_FAULTS, `TLFR_CMD_STATUS, `TLFR_CMD_OT_WARN,
        `TLFR_CMD_UT_WARN, `TLFR_CMD_UT_FAULT,
        `TLFR_CMD_UT_ACTION: cmd_known = 1'b1;
        default: cmd_known = 1'b0;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg scl_m_reg, scl_s_reg, scl_p_reg;
  reg sda_m_reg, sda_s_reg, sda_p_reg;
  reg ctl_m_reg, ctl_s_reg;

  always @(posedge clk_sys) begin
    if (reset) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_p_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_p_reg <= 1'b1;
      ctl_m_reg <= 1'b0;
      ctl_s_reg <= 1'b0;
    end else begin
      scl_m_reg <= pmb_scl_in;
      scl_s_reg <= scl_m_reg;
      scl_p_reg <= scl_s_reg;
      sda_m_reg <= pmb_sda_in;
      sda_s_reg <= sda_m_reg;
      sda_p_reg <= sda_s_reg;
      ctl_m_reg <= ctrl_on_in;
      ctl_s_reg <= ctl_m_reg;
    end
  end

  wire scl_rise = scl_s_reg & ~scl_p_reg;
  wire scl_fall = ~scl_s_reg & scl_p_reg;
  wire bus_start = scl_s_reg & scl_p_reg & ~sda_s_reg & sda_p_reg;
  wire bus_stop = scl_s_reg & scl_p_reg & sda_s_reg & ~sda_p_reg;

  //////////////////////////////////////////////////////////////////////////
  // registers
  reg [15:0] over_temp_warning_limit_reg;
  reg [15:0] under_temp_warning_limit_reg;
  reg [15:0] under_temp_fault_limit_reg;
  reg [7:0] under_temp_fault_action_reg;

  reg [2:0] ps_reg;
  reg [3:0] bit_reg;
  reg [7:0] sh_reg;
  reg [7:0] cmd_reg;
  reg [1:0] widx_reg;
  reg [15:0] wdat_reg;
  reg ridx_reg;
  reg sda_lo_reg;
  reg wr_go_reg;
  reg [15:0] rd_word;

  assign pmb_sda_out = 1'b0;
  assign pmb_sda_oe_n = ~sda_lo_reg;

  always @* begin
    case (cmd_reg)
      `TLFR_CMD_OT_WARN: rd_word = over_temp_warning_limit_reg;
      `TLFR_CMD_UT_WARN: rd_word = under_temp_warning_limit_reg;
      `TLFR_CMD_UT_FAULT: rd_word = under_temp_fault_limit_reg;
      `TLFR_CMD_UT_ACTION: rd_word = {8'h00, under_temp_fault_action_reg};
      `TLFR_CMD_STATUS: rd_word = {8'h00, 1'b0, ot_warning, ut_warning,
        ut_fault, 4'h0};
      default: rd_word = 16'hFFFF;
    endcase
  end

  wire [7:0] tx_byte = ridx_reg ? rd_word[15:8] : rd_word[7:0];
  wire [3:0] nb = (bit_reg == 4'd9) ? 4'd0 : bit_reg;

  // byte engine: samples on scl rise, drives on scl fall
  always @(posedge clk_sys) begin
    if (reset) begin
      ps_reg <= PS_IDLE;
      bit_reg <= 4'd0;
      sh_reg <= 8'h00;
      cmd_reg <= 8'h00;
      widx_reg <= 2'd0;
      wdat_reg <= 16'h0000;
      ridx_reg <= 1'b0;
      sda_lo_reg <= 1'b0;
      wr_go_reg <= 1'b0;
    end else begin
      wr_go_reg <= 1'b0;
      if (bus_start) begin
        ps_reg <= PS_ADDR;
        bit_reg <= 4'd0;
        sda_lo_reg <= 1'b0;
      end else if (bus_stop) begin
        wr_go_reg <= (ps_reg == PS_WDATA);
        ps_reg <= PS_IDLE;
        sda_lo_reg <= 1'b0;
      end else if (ps_reg != PS_IDLE && scl_rise) begin
        if (bit_reg < 4'd8) begin
          sh_reg <= {sh_reg[6:0], sda_s_reg};
          bit_reg <= bit_reg + 4'd1;
        end else if (bit_reg == 4'd9 && ps_reg == PS_RDATA && sda_s_reg) begin
          ps_reg <= PS_IDLE; // host ends the read with a nack
        end
      end else if (ps_reg != PS_IDLE && scl_fall) begin
        if (bit_reg == 4'd8) begin
          bit_reg <= 4'd9;
          sda_lo_reg <= 1'b0;
          case (ps_reg)
            PS_ADDR: begin
              if (sh_reg[7:1] == DEV_ADDR) begin
                sda_lo_reg <= 1'b1;
                ps_reg <= sh_reg[0] ? PS_RDATA : PS_CMD;
                ridx_reg <= 1'b0;
              end else begin
                ps_reg <= PS_IDLE;
              end
            end
            PS_CMD: begin
              cmd_reg <= sh_reg;
              widx_reg <= 2'd0;
              sda_lo_reg <= cmd_known(sh_reg);
              ps_reg <= cmd_known(sh_reg) ? PS_WDATA : PS_IDLE;
            end
            PS_WDATA: begin
              // low byte first, as words travel on the link
              if (widx_reg == 2'd0) begin
                wdat_reg[7:0] <= sh_reg;
              end else begin
                wdat_reg[15:8] <= sh_reg;
              end
              if (widx_reg < 2'd2) begin
                widx_reg <= widx_reg + 2'd1;
                sda_lo_reg <= 1'b1;
              end else begin
                widx_reg <= 2'd3;
              end
            end
            default: begin
              ridx_reg <= ~ridx_reg;
            end
          endcase
        end else begin
          if (bit_reg == 4'd9) begin
            bit_reg <= 4'd0;
          end
          if (ps_reg == PS_RDATA && nb < 4'd8) begin
            sda_lo_reg <= ~tx_byte[3'd7 - nb[2:0]];
          end else begin
            sda_lo_reg <= 1'b0;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register writes, committed at the stop condition
  wire wr_word = wr_go_reg && widx_reg == 2'd2;
  wire wr_byte = wr_go_reg && widx_reg == 2'd1;
  wire clear_faults = wr_go_reg && widx_reg == 2'd0 &&
    cmd_reg == `TLFR_CMD_CLEAR_FAULTS;
  wire stat_wr = wr_byte && cmd_reg == `TLFR_CMD_STATUS;
  wire clr_ot = clear_faults | (stat_wr & wdat_reg[`TLFR_STAT_OT_WARN]);
  wire clr_uw = clear_faults | (stat_wr & wdat_reg[`TLFR_STAT_UT_WARN]);
  wire clr_uf = clear_faults | (stat_wr & wdat_reg[`TLFR_STAT_UT_FAULT]);

  always @(posedge clk_sys) begin
    if (reset) begin
      over_temp_warning_limit_reg <= `TLFR_RST_OT_WARN;
      under_temp_warning_limit_reg <= `TLFR_RST_UT_WARN;
      under_temp_fault_limit_reg <= `TLFR_RST_UT_FAULT;
      under_temp_fault_action_reg <= `TLFR_RST_UT_ACTION;
    end else begin
      if (wr_word && cmd_reg == `TLFR_CMD_OT_WARN) begin
        over_temp_warning_limit_reg <= wdat_reg;
      end
      if (wr_word && cmd_reg == `TLFR_CMD_UT_WARN) begin
        under_temp_warning_limit_reg <= wdat_reg;
      end
      if (wr_word && cmd_reg == `TLFR_CMD_UT_FAULT) begin
        under_temp_fault_limit_reg <= wdat_reg;
      end
      if (wr_byte && cmd_reg == `TLFR_CMD_UT_ACTION) begin
        under_temp_fault_action_reg <= wdat_reg[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // limit comparison and sticky status; a set beats a clear
  reg ot_now_reg, uw_now_reg, uf_now_reg;

  always @(posedge clk_sys) begin
    if (reset) begin
      ot_now_reg <= 1'b0;
      uw_now_reg <= 1'b0;
      uf_now_reg <= 1'b0;
      ot_warning <= 1'b0;
      ut_warning <= 1'b0;
      ut_fault <= 1'b0;
    end else begin
      ot_now_reg <= lin_fix(temp_meas) >
        lin_fix(over_temp_warning_limit_reg);
      uw_now_reg <= lin_fix(temp_meas) <
        lin_fix(under_temp_warning_limit_reg);
      uf_now_reg <= lin_fix(temp_meas) <
        lin_fix(under_temp_fault_limit_reg);
      ot_warning <= ot_now_reg | (ot_warning & ~clr_ot);
      ut_warning <= uw_now_reg | (ut_warning & ~clr_uw);
      ut_fault <= uf_now_reg | (ut_fault & ~clr_uf);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // fault action state machine
  wire [1:0] resp = under_temp_fault_action_reg[`TLFR_RESP_HI:`TLFR_RESP_LO];
  wire [2:0] retries =
    under_temp_fault_action_reg[`TLFR_RETRY_HI:`TLFR_RETRY_LO];
  wire [2:0] dly = under_temp_fault_action_reg[`TLFR_DELAY_HI:`TLFR_DELAY_LO];
  wire cmd_on = operation_on & ctl_s_reg;
  wire more_tries;

  reg [2:0] st_reg, st_next;
  reg [2:0] try_reg, try_next;
  reg tmr_start;
  wire tmr_done;

  // unlimited attempts at 111, otherwise the count caps them
  assign more_tries = (retries == 3'b111) || (try_reg < retries);

  always @* begin
    st_next = st_reg;
    try_next = try_reg;
    tmr_start = 1'b0;
    if (!cmd_on) begin
      st_next = ST_OFF;
    end else begin
      case (st_reg)
        ST_OFF: begin
          st_next = ST_RUN;
          try_next = 3'd0;
        end
        ST_RUN: begin
          if (uf_now_reg) begin
            case (resp)
              2'b00: st_next = ST_RUN;
              2'b01: begin
                st_next = ST_HOLD;
                tmr_start = 1'b1;
              end
              2'b10: begin
                try_next = 3'd0;
                if (retries == 3'b000) begin
                  st_next = ST_LATCH;
                end else begin
                  st_next = ST_WAIT;
                  tmr_start = 1'b1;
                end
              end
              default: st_next = ST_LATCH;
            endcase
          end
        end
        ST_HOLD: begin
          if (!uf_now_reg) begin
            st_next = ST_RUN;
          end else if (tmr_done) begin
            try_next = 3'd0;
            if (retries == 3'b000) begin
              st_next = ST_LATCH;
            end else begin
              st_next = ST_WAIT;
              tmr_start = 1'b1;
            end
          end
        end
        ST_WAIT: begin
          if (tmr_done) begin
            st_next = ST_TRY;
            try_next = (try_reg == 3'd7) ? 3'd7 : try_reg + 3'd1;
            tmr_start = 1'b1;
          end
        end
        ST_TRY: begin
          if (uf_now_reg) begin
            if (more_tries) begin
              st_next = ST_WAIT;
              tmr_start = 1'b1;
            end else begin
              st_next = ST_LATCH;
            end
          end else if (tmr_done) begin
            st_next = ST_RUN;
            try_next = 3'd0;
          end
        end
        ST_LATCH: begin
          if (clr_uf) begin
            st_next = ST_RUN;
            try_next = 3'd0;
          end
        end
        default: st_next = ST_OFF;
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      st_reg <= ST_OFF;
      try_reg <= 3'd0;
      power_enable <= 1'b0;
      fault_latched <= 1'b0;
    end else begin
      st_reg <= st_next;
      try_reg <= try_next;
      power_enable <= (st_next == ST_RUN) || (st_next == ST_HOLD) ||
        (st_next == ST_TRY);
      fault_latched <= (st_next == ST_LATCH);
    end
  end

  tlfr_delay_timer #(
    .UNIT_W(UNIT_W)
  ) u_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(tmr_start),
    .exp_sel(dly),
    .unit_cycles(delay_unit_cycles),
    .busy(),
    .done(tmr_done)
  );

endmodule // tlfr_top

/* File: test/tlfr_top_sva.sv */
// port assertions for the temperature limit block
`timescale 1ns/1ps
module tlfr_top_sva (
  input wire clk_sys,
  input wire reset,
  input wire pmb_scl_in,
  input wire pmb_sda_out,
  input wire pmb_sda_oe_n,
  input wire ctrl_on_in,
  input wire operation_on,
  input wire power_enable,
  input wire ut_fault,
  input wire fault_latched
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  sequence s_drive_hold;
    !pmb_sda_oe_n [*8];
  endsequence
  sequence s_cmd_off;
    !operation_on [*4];
  endsequence
  sequence s_ctrl_off;
    !ctrl_on_in [*6];
  endsequence
  a_sda_value: assert property (pmb_sda_out == 1'b0)
    else $error("sda drive value not low");
  a_sda_moves: assert property ($changed(pmb_sda_oe_n) |->
    !pmb_scl_in && $past(pmb_scl_in, 6))
    else $error("sda changed outside clock low phase");
  a_drive_holds: assert property ($fell(pmb_sda_oe_n) |->
    s_drive_hold)
    else $error("sda drive too short");
  a_rise_needs_cmd: assert property ($rose(power_enable) |->
    $past(operation_on))
    else $error("output rose without on command");
  a_cmd_off: assert property (s_cmd_off |-> !power_enable)
    else $error("output on while commanded off");
  a_ctrl_off: assert property (s_ctrl_off |-> !power_enable)
    else $error("output on while control pin off");
  a_latch_off: assert property (fault_latched |->
    !power_enable && ut_fault)
    else $error("output on or flag clear while latched");
  a_latch_flag: assert property ($rose(fault_latched) |->
    ##[0:3] ut_fault)
    else $error("latch without fault flag");
endmodule // tlfr_top_sva

bind tlfr_top tlfr_top_sva tlfr_top_sva_inst (.clk_sys(clk_sys),
  .reset(reset), .pmb_scl_in(pmb_scl_in), .pmb_sda_out(pmb_sda_out),
  .pmb_sda_oe_n(pmb_sda_oe_n), .ctrl_on_in(ctrl_on_in),
  .operation_on(operation_on), .power_enable(power_enable),
  .ut_fault(ut_fault), .fault_latched(fault_latched));

/* File: test/tlfr_host_model.sv */
// link host model: framing, byte transfers, register access
`timescale 1ns/1ps
module tlfr_host_model #(
  parameter logic [6:0] ADDR = 7'h40
) (
  output reg scl,
  output reg sda_low,
  input wire sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // clock stands high between frames
  task start;
    #20 sda_low = 1'b0;
    scl = 1'b1;
    #20 sda_low = 1'b1;
    #20 scl = 1'b0;
  endtask
  task stop;
    #20 sda_low = 1'b1;
    #20 scl = 1'b1;
    #20 sda_low = 1'b0;
    #40;
  endtask
  task xfer(input logic [7:0] d, input logic m, output logic [7:0] q,
    output logic ack);
    logic r;
    begin
      for (int i = 8; i >= 0; i--) begin
        #20 sda_low = (i == 0) ? !m : !d[i-1];
        #20 scl = 1'b1;
        #20 r = sda;
        #20 scl = 1'b0;
        if (i > 0) q[i-1] = r;
      end
      ack = !r;
    end
  endtask
  // words go low byte first
  task wr(input logic [7:0] c, input logic [15:0] v, input int n,
    output logic ok);
    logic [7:0] q;
    logic a;
    begin
      start();
      xfer({ADDR, 1'b0}, 1'b1, q, ok);
      xfer(c, 1'b1, q, a);
      ok &= a;
      if (n > 0) xfer(v[7:0], 1'b1, q, a);
      ok &= a;
      if (n > 1) xfer(v[15:8], 1'b1, q, a);
      ok &= a;
      stop();
    end
  endtask
  task rd(input logic [7:0] c, input int n, output logic [15:0] v,
    output logic ok);
    logic [7:0] q;
    logic a;
    begin
      v = 16'h0000;
      start();
      xfer({ADDR, 1'b0}, 1'b1, q, ok);
      xfer(c, 1'b1, q, a);
      ok &= a;
      start();
      xfer({ADDR, 1'b1}, 1'b1, q, a);
      ok &= a;
      xfer(8'hFF, n == 1, q, a);
      v[7:0] = q;
      if (n > 1) xfer(8'hFF, 1'b1, q, a);
      if (n > 1) v[15:8] = q;
      stop();
    end
  endtask
endmodule // tlfr_host_model

/* File: test/tlfr_top_tb_top.sv */
// self-checking bench for the temperature limit block
`timescale 1ns/1ps
module tlfr_top_tb_top;
  localparam int U = 4;
  typedef struct {logic [7:0] c; int n; logic [15:0] v, r;} tlfr_reg_t;
  typedef struct {logic [7:0] a; logic e; logic [2:0] l;} tlfr_rsp_t;
  tlfr_reg_t regs[4] = '{'{8'h51, 2, 16'h0028, 16'h0000},
    '{8'h52, 2, 16'h000F, 16'h0000}, '{8'h53, 2, 16'h000A, 16'h0000},
    '{8'h54, 1, 16'h00B5, 16'h00C0}};
  tlfr_rsp_t rsps[4] = '{'{8'h01, 1'b1, 3'b101}, '{8'h41, 1'b1, 3'b011},
    '{8'h81, 1'b0, 3'b011}, '{8'hC1, 1'b0, 3'b011}};
  logic clk_sys, reset, ctrl_on_in, operation_on, ok, pe_d;
  logic [15:0] temp_meas, v, unit_cyc;
  wire scl, sda_low, pmb_sda_out, pmb_sda_oe_n, power_enable, ot_warning;
  wire ut_warning, ut_fault, fault_latched;
  // pull-up: high unless a party pulls low
  wire sda = !(sda_low || !pmb_sda_oe_n);
  int err_total, checks, cyc, rises, cnt;
  tlfr_top tlfr_top_inst (.clk_sys(clk_sys), .reset(reset),
    .pmb_scl_in(scl), .pmb_sda_in(sda), .pmb_sda_out(pmb_sda_out),
    .pmb_sda_oe_n(pmb_sda_oe_n), .ctrl_on_in(ctrl_on_in),
    .operation_on(operation_on), .delay_unit_cycles(unit_cyc),
    .temp_meas(temp_meas), .power_enable(power_enable),
    .ot_warning(ot_warning), .ut_warning(ut_warning), .ut_fault(ut_fault),
    .fault_latched(fault_latched));
  tlfr_host_model tlfr_host_model_inst (.scl(scl), .sda_low(sda_low),
    .sda(sda));
  ////////////////////////////////////////////////////////////////////////
  task cmp(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task set_t(input logic [15:0] t);
    @(posedge clk_sys);
    temp_meas <= t;
  endtask
  task pulse(input int w);
    @(posedge clk_sys);
    if (w == 2) ctrl_on_in <= 1'b0;
    else operation_on <= 1'b0;
    tick(10);
    ctrl_on_in <= 1'b1;
    operation_on <= 1'b1;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // attempt counter and hang guard
  always @(posedge clk_sys) begin
    pe_d <= power_enable;
    if (power_enable && !pe_d) rises++;
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    reset = 1'b1;
    ctrl_on_in = 1'b1;
    operation_on = 1'b1;
    temp_meas = 16'h0014;
    unit_cyc = U[15:0];
    tick(4);
    reset <= 1'b0;
    tick(1);
    #1;
    cmp({power_enable, ut_fault, fault_latched, pmb_sda_oe_n}, 16'h0001);
    tick(4);
    #1;
    cmp(power_enable, 1'b1);
    $display("test reset done");
    foreach (regs[i]) begin
      tlfr_host_model_inst.rd(regs[i].c, regs[i].n, v, ok);
      cmp(v, regs[i].r);
      tlfr_host_model_inst.wr(regs[i].c, regs[i].v, regs[i].n, ok);
      tlfr_host_model_inst.rd(regs[i].c, regs[i].n, v, ok);
      cmp(v, regs[i].v);
      cmp(ok, 1'b1);
    end
    // unknown command must not be acknowledged
    tlfr_host_model_inst.wr(8'hA0, 16'h1234, 2, ok);
    cmp(ok, 1'b0);
    $display("test registers done");
    tlfr_host_model_inst.wr(8'h7D, 16'h0070, 1, ok);
    set_t(16'h002D);
    tick(3);
    #1;
    cmp({ot_warning, ut_warning, power_enable}, 16'h0005);
    set_t(16'h000C);
    tick(3);
    #1;
    cmp({ut_warning, ut_fault, power_enable}, 16'h0005);
    set_t(16'h0014);
    $display("test warnings done");
    foreach (rsps[i]) begin
      tlfr_host_model_inst.wr(8'h54, {8'h00, rsps[i].a}, 1, ok);
      set_t(16'h0005);
      tick(4);
      #1;
      cmp(power_enable, rsps[i].e);
      tick(40);
      #1;
      cmp({power_enable, fault_latched, ut_fault}, rsps[i].l);
      set_t(16'h0014);
      if (i == 0) tlfr_host_model_inst.wr(8'h03, 16'h0000, 0, ok);
      if (i == 1) tlfr_host_model_inst.wr(8'h7D, 16'h0010, 1, ok);
      if (i > 1) pulse(i);
      tick(30);
      #1;
      cmp({power_enable, fault_latched}, 16'h0002);
    end
    $display("test responses done");
    for (int n = 1; n <= 7; n++) begin
      tlfr_host_model_inst.wr(8'h54, {10'h002, n[2:0], 3'h1}, 1, ok);
      rises = 0;
      set_t(16'h0005);
      tick(300);
      #1;
      if (n < 7) cmp(rises[15:0], n[15:0]);
      else cmp(rises > 6, 1'b1);
      cmp(fault_latched, n < 7);
      operation_on <= 1'b0;
      tick(20);
      #1;
      rises = 0;
      tick(60);
      #1;
      cmp({rises[14:0], power_enable}, 16'h0000);
      set_t(16'h0014);
      operation_on <= 1'b1;
      tick(20);
    end
    $display("test retries done");
    // last pass changes the unit length itself
    for (int d = 0; d < 9; d++) begin
      if (d == 8) unit_cyc <= 16'h0008;
      tlfr_host_model_inst.wr(8'h54, {13'h0008, d[2:0]}, 1, ok);
      cnt = 0;
      set_t(16'h0005);
      while (power_enable === 1'b1 && cnt < 700) begin
        tick(1);
        #1;
        cnt++;
      end
      // run-on is 2^d[2:0] units of unit_cyc cycles, plus detection latency
      cmp(cnt >= (unit_cyc << d[2:0]) &&
        cnt <= (unit_cyc << d[2:0]) + 6, 1'b1);
      set_t(16'h0014);
      tlfr_host_model_inst.wr(8'h03, 16'h0000, 0, ok);
    end
    unit_cyc <= U[15:0];
    $display("test delays done");
    tlfr_host_model_inst.wr(8'h54, 16'h00C0, 1, ok);
    set_t(16'h0005);
    tick(20);
    set_t(16'h0014);
    reset <= 1'b1;
    tick(4);
    reset <= 1'b0;
    tick(4);
    #1;
    cmp({fault_latched, power_enable}, 16'h0001);
    tlfr_host_model_inst.rd(8'h54, 1, v, ok);
    cmp(v, 16'h00C0);
    $display("test reset clear done");
    end_sim();
  end
endmodule // tlfr_top_tb_top
